/* File: design/wdog_pkg.sv */
// Package for the board watchdog: period selection codes and timing counts.
// Assumes a single 200 MHz board clock.
package wdog_pkg;

	// ----------------------------------------
	// Clock and time base
	// ----------------------------------------
	localparam int unsigned CLK_HZ            = 200_000_000;
	localparam int unsigned CLK_PERIOD_PS     = 5000;
	localparam int unsigned SECOND_MS         = 1000;
	localparam int unsigned CYCLES_PER_SECOND = SECOND_MS * (CLK_HZ / 1000);

	// ----------------------------------------
	// Period selection
	// ----------------------------------------
	typedef enum logic [1:0] {
		PERIOD_2S   = 2'h0,
		PERIOD_10S  = 2'h1,
		PERIOD_50S  = 2'h2,
		PERIOD_255S = 2'h3
	} period_sel_t;

	localparam logic [7:0] PERIOD_2_SEC   = 8'h02;
	localparam logic [7:0] PERIOD_10_SEC  = 8'h0A;
	localparam logic [7:0] PERIOD_50_SEC  = 8'h32;
	localparam logic [7:0] PERIOD_255_SEC = 8'hFF;
	localparam int unsigned SEC_W         = 8;

	// ----------------------------------------
	// Reset values and output pulse
	// ----------------------------------------
	localparam period_sel_t PERIOD_RESET   = PERIOD_2S;
	localparam int unsigned RESET_PULSE_CY = 16;

	// Watchdog arm states
	typedef enum logic [1:0] {
		ST_PASSIVE = 2'b00,
		ST_ACTIVE  = 2'b01,
		ST_FIRED   = 2'b10
	} wd_state_t;

	// Period code to whole seconds, used by core and checks
	function automatic logic [7:0] period_seconds(input period_sel_t sel);
		case (sel)
			PERIOD_2S:   period_seconds = PERIOD_2_SEC;
			PERIOD_10S:  period_seconds = PERIOD_10_SEC;
			PERIOD_50S:  period_seconds = PERIOD_50_SEC;
			PERIOD_255S: period_seconds = PERIOD_255_SEC;
			default:     period_seconds = PERIOD_2_SEC;
		endcase
	endfunction

endpackage

/* File: design/wdog_second_tick.sv */
// One-second tick generator for the watchdog.
// Assumes a synchronous clear from the watchdog core; counts only when enabled.
`timescale 1ns/1ps
module wdog_second_tick #(
	parameter int unsigned CYCLES = wdog_pkg::CYCLES_PER_SECOND
) (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_ce,
	input  wire logic i_clear,
	output logic      o_tick
);
	import wdog_pkg::*;

	localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;

	// Prescaler; clear restarts the second so a trigger restarts from zero
	always_comb begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (i_clear) begin
			cnt_next = '0;
		end else if (cnt_reg == LAST) begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (i_ce) begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;

endmodule // wdog_second_tick

/* File: design/board_watchdog_timer.sv */
// Board watchdog core: passive after reset, armed by the first trigger,
// forces a full system reset when triggers stop for longer than the selected period.
// Assumes trigger and period selection come from board control logic,
// synchronous to i_clk, and that o_sys_reset feeds the board reset tree.
`timescale 1ns/1ps

// Functional notes
// R1: Timeout period selectable among exactly 2, 10, 50 and 255 seconds.
// R2: After system reset the watchdog is passive and does not count.
// R3: First trigger after reset makes the watchdog active.
// R4: Active and trigger gap exceeds period: timeout, full system reset.
// R5: Once active stays active until reset; no disable control exists.
// R6: New period selection accepted any time, passive or active.
// R7: Software must trigger more often than the selected period.
// R8: Count restarts at every trigger, whole seconds, compared to current period.
module board_watchdog_timer #(
	parameter int unsigned  CYCLES_PER_SEC = wdog_pkg::CYCLES_PER_SECOND,
	parameter int unsigned  PULSE_CYCLES   = wdog_pkg::RESET_PULSE_CY
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_ce,
	input  wire logic                  i_trigger,
	input  wire logic                  i_period_we,
	input  wire wdog_pkg::period_sel_t i_period_sel,
	output logic                       o_active,
	output wdog_pkg::period_sel_t      o_period,
	output logic [wdog_pkg::SEC_W-1:0] o_seconds,
	output logic                       o_sys_reset
);
	import wdog_pkg::*;

	localparam int unsigned PW = (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES + 1) : 1;
	localparam logic [PW-1:0] PULSE_LEN = PW'(PULSE_CYCLES);

	// ----------------------------------------
	// State
	// ----------------------------------------
	wd_state_t        state_reg;
	wd_state_t        state_next;
	period_sel_t      period_reg;
	period_sel_t      period_next;
	logic [SEC_W-1:0] sec_reg;
	logic [SEC_W-1:0] sec_next;
	logic [PW-1:0]    pulse_reg;
	logic [PW-1:0]    pulse_next;
	logic             rst_out_reg;
	logic             rst_out_next;
	logic             active_reg;
	logic             active_next;
	logic             tick;
	logic             clear_tick;

	// Prescaler runs only while armed and is restarted by every trigger
	assign clear_tick = i_trigger || (state_reg != ST_ACTIVE);

	wdog_second_tick #(
		.CYCLES (CYCLES_PER_SEC)
	) u_tick (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_clear   (clear_tick),
		.o_tick    (tick)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_next   = state_reg;
		period_next  = period_reg;
		sec_next     = sec_reg;
		pulse_next   = pulse_reg;
		rst_out_next = 1'b0;
		// R6: period reload anytime
		if (i_period_we) begin
			period_next = i_period_sel;
		end
		case (state_reg)
			// R2: passive, no counting
			ST_PASSIVE: begin
				sec_next = '0;
				// R3: arm on first trigger
				if (i_trigger) begin
					state_next = ST_ACTIVE;
				end
			end
			// R5: no path back to passive
			ST_ACTIVE: begin
				// R8: restart count per trigger
				if (i_trigger) begin
					sec_next = '0;
				end else if (tick) begin
					// R1: limit is one of four periods
					// R4: timeout when count passes period
					if (sec_reg >= period_seconds(period_reg)) begin
						state_next   = ST_FIRED;
						pulse_next   = PULSE_LEN;
						rst_out_next = 1'b1;
					end else begin
						sec_next = sec_reg + 1'b1;
					end
				end
			end
			// Holds reset until the board reset tree clears us
			ST_FIRED: begin
				if (pulse_reg > 1) begin
					pulse_next   = pulse_reg - 1'b1;
					rst_out_next = 1'b1;
				end else begin
					pulse_next   = '0;
					rst_out_next = 1'b1;
				end
			end
			default: begin
				state_next = ST_PASSIVE;
			end
		endcase
		// Armed flag registered so the output needs no decode
		active_next = (state_next != ST_PASSIVE);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Registers; asynchronous reset returns everything to passive
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg   <= ST_PASSIVE;
			period_reg  <= PERIOD_RESET;
			sec_reg     <= '0;
			pulse_reg   <= '0;
			rst_out_reg <= 1'b0;
			active_reg  <= 1'b0;
		end else if (i_ce) begin
			state_reg   <= state_next;
			period_reg  <= period_next;
			sec_reg     <= sec_next;
			pulse_reg   <= pulse_next;
			rst_out_reg <= rst_out_next;
			active_reg  <= active_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Outputs straight from flip-flops
	assign o_active    = active_reg;
	assign o_period    = period_reg;
	assign o_seconds   = sec_reg;
	assign o_sys_reset = rst_out_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_arm;
		i_ce && i_trigger && state_reg == ST_PASSIVE;
	endsequence

	sequence s_expire;
		i_ce && state_reg == ST_ACTIVE && !i_trigger && tick
			&& sec_reg >= period_seconds(period_reg);
	endsequence

	// Period limit rebuilt from the constants, apart from the core's decode
	logic [SEC_W-1:0] chk_limit;
	assign chk_limit = (period_reg == PERIOD_2S)  ? PERIOD_2_SEC :
		(period_reg == PERIOD_10S) ? PERIOD_10_SEC :
		(period_reg == PERIOD_50S) ? PERIOD_50_SEC : PERIOD_255_SEC;

	sequence s_early_tick;
		i_ce && state_reg == ST_ACTIVE && !i_trigger && tick && sec_reg < chk_limit;
	endsequence

	chk_period_encode: assert property ( // R1
		s_early_tick |=> state_reg == ST_ACTIVE && sec_reg == $past(sec_reg) + 8'h01)
		else $error("watchdog fired before selected period");

	chk_passive_idle: assert property ( // R2
		state_reg == ST_PASSIVE |-> sec_reg == '0 && !o_sys_reset)
		else $error("passive watchdog counting or resetting");

	chk_arm_first: assert property ( // R3
		s_arm |=> state_reg == ST_ACTIVE)
		else $error("first trigger did not arm");

	chk_timeout_fire: assert property ( // R4
		s_expire |=> o_sys_reset && state_reg == ST_FIRED)
		else $error("timeout did not reset system");

	chk_no_disarm: assert property ( // R5
		state_reg != ST_PASSIVE |=> state_reg != ST_PASSIVE)
		else $error("watchdog disarmed without reset");

	chk_period_load: assert property ( // R6
		i_ce && i_period_we |=> period_reg == $past(i_period_sel))
		else $error("period selection not taken");

	chk_trig_restart: assert property ( // R8
		i_ce && i_trigger && state_reg == ST_ACTIVE |=> sec_reg == '0 && !o_sys_reset)
		else $error("trigger did not restart count");

	chk_fired_holds: assert property ( // R4
		state_reg == ST_FIRED |-> o_sys_reset || $past(state_reg) != ST_FIRED)
		else $error("reset output dropped while fired");

	chk_ce_freeze: assert property ( // R8
		!i_ce |=> $stable(state_reg) && $stable(sec_reg) && $stable(period_reg) && $stable(o_sys_reset))
		else $error("state moved while clock enable low");

	chk_fire_sticky: assert property ( // R4
		o_sys_reset |=> o_sys_reset)
		else $error("system reset released before reset");

	chk_active_out: assert property ( // R5
		state_reg != ST_PASSIVE |-> o_active)
		else $error("armed watchdog not shown active");

endmodule // board_watchdog_timer

/* File: test/wdog_host.sv */
// Host software model: issues trigger requests and period writes.
// Assumes the bench clock; drives on falling edges.
`timescale 1ns/1ps
module wdog_host (
	input  wire logic             i_clk,
	output logic                  o_trigger,
	output wdog_pkg::period_sel_t o_period_sel,
	output logic                  o_period_we
);
	import wdog_pkg::*;
	// Idle levels from time zero
	initial begin
		o_trigger = 1'b0;
		o_period_we = 1'b0;
		o_period_sel = PERIOD_2S;
	end
	task automatic kick();
		@(negedge i_clk) o_trigger = 1'b1;
		@(negedge i_clk) o_trigger = 1'b0;
	endtask
	task automatic set_period(input period_sel_t s);
		@(negedge i_clk) begin
			o_period_we = 1'b1;
			o_period_sel = s;
		end
		@(negedge i_clk) o_period_we = 1'b0;
	endtask
endmodule // wdog_host

/* File: test/board_watchdog_timer_test.sv */
// Self-checking bench for the board watchdog.
// Assumes a shortened second of C cycles; host model drives triggers.
`timescale 1ns/1ps
module board_watchdog_timer_test;
	import wdog_pkg::*;
	// ----------------------------------------
	// Clock, reset and wiring
	// ----------------------------------------
	localparam int C = 10;
	logic        i_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        trig;
	logic        ce = 1'b1;
	logic        pwe;
	period_sel_t psel;
	logic        active;
	period_sel_t period;
	logic [7:0]  seconds;
	logic        sys_reset;
	int          error_cnt = 0;
	int          checks = 0;
	int          n;
	always #2.5 i_clk = ~i_clk;
	wdog_host host (.i_clk(i_clk), .o_trigger(trig), .o_period_sel(psel), .o_period_we(pwe));
	// Clock enable driven by the bench so the freeze path is exercised
	board_watchdog_timer #(.CYCLES_PER_SEC(C), .PULSE_CYCLES(16)) dut (
		.i_clk(i_clk), .i_reset_n(rst_n), .i_ce(ce), .i_trigger(trig),
		.i_period_we(pwe), .i_period_sel(psel), .o_active(active),
		.o_period(period), .o_seconds(seconds), .o_sys_reset(sys_reset));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Seconds for a period code, worked out independently
	function automatic int secs(input int c);
		return (c == 0) ? 2 : (c == 1) ? 10 : (c == 2) ? 50 : 255;
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic do_reset(input int cy);
		rst_n = 1'b0;
		repeat (cy) @(negedge i_clk);
		rst_n = 1'b1;
	endtask
	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h714e8096));
		do_reset(12);
		check("active", 8'h00, active);
		check("period", 8'h00, period);
		repeat (5 * C) @(negedge i_clk);
		check("seconds", 8'h00, seconds);
		check("sys_reset", 8'h00, sys_reset);
		$display("test passive done");
		// Random gaps always shorter than two seconds keep it alive
		host.kick();
		check("active", 8'h01, active);
		check("seconds", 8'h00, seconds);
		for (int i = 0; i < 20; i++) begin
			repeat ($urandom_range(2 * C - 3, 1)) @(negedge i_clk);
			host.kick();
			check("seconds", 8'h00, seconds);
		end
		check("sys_reset", 8'h00, sys_reset);
		host.set_period(PERIOD_10S);
		check("period", 8'h01, period);
		check("active", 8'h01, active);
		$display("test keepalive done");
		// Freeze: clock enable low must hold the count after a trigger
		host.kick();
		ce = 1'b0;
		repeat (3 * C) @(negedge i_clk);
		check("seconds", 8'h00, seconds);
		check("sys_reset", 8'h00, sys_reset);
		ce = 1'b1;
		repeat (2 * C) @(negedge i_clk);
		check("seconds", 8'h01, seconds);
		$display("test freeze done");
		// Every code: no fire 2 cycles before its period ends, fire within 2*C+4 cycles after that
		for (int k = 0; k < 4; k++) begin
			do_reset(3);
			host.set_period(period_sel_t'(k));
			check("period", k[7:0], period);
			host.kick();
			repeat (secs(k) * C - 2) @(negedge i_clk);
			check("sys_reset", 8'h00, sys_reset);
			check("seconds", 8'(secs(k) - 1), seconds);
			n = 0;
			while (sys_reset !== 1'b1 && n < 2 * C + 4) begin
				@(negedge i_clk);
				n++;
			end
			check("fire_delay", 8'h01, {7'h00, n >= C - 2 && n < 2 * C + 4});
			check("active", 8'h01, active);
			$display("test timeout code %0d done", k);
		end
		close_out();
	end
endmodule // board_watchdog_timer_test
